//--- ssf_consts.vh
// Constants for the sensor status flag block: offsets, bit positions, resets, timing.
// Assumes a 40 MHz core clock; included by bare name.
// Function
// RL1: Any reset sets reset-occurred flag bit 1.
// RL2: Status read or transmitted status clears reset flag.
// RL3: Init flag set at reset until data valid.
// RL4: Undervoltage sets supply error bit 7.
// RL5: Analog regulator fault sets bit 3.
// RL6: Digital regulator fault sets bit 2.
// RL7: OTP regulator fault sets bit 1.
// RL8: Continuity break sets bit 0, resets zero.
// RL9: Shared recovery timer reloads while any fault.
// RL10: Report-disable setting decides how bits clear.
// RL11: Host ignores supply flags during reset/init.
// RL12: Summary bit 3 is OR of supply errors.
// RL13: Status registers read-only over SPI and I2C.
// RL14: Clear only after fault-free full recovery interval.
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH
`define SSF_OFS_MAIN_STATUS   8'h01
`define SSF_OFS_SUPPLY_STATUS 8'h02
`define SSF_BIT_INIT          0
`define SSF_BIT_RESET         1
`define SSF_BIT_SUPPLY_SUM    3
`define SSF_BIT_CONT          0
`define SSF_BIT_OTP_REG       1
`define SSF_BIT_DIG_REG       2
`define SSF_BIT_ANA_REG       3
`define SSF_BIT_UV            7
`define SSF_RESET_SUPPLY      8'h00
`define SSF_CLK_MHZ           40
`define SSF_RECOVERY_US       100
`define SSF_RECOVERY_CYCLES   (`SSF_RECOVERY_US * `SSF_CLK_MHZ)
`define SSF_DATA_VALID_US     1000
`define SSF_DATA_VALID_CYCLES (`SSF_DATA_VALID_US * `SSF_CLK_MHZ)
`define SSF_TIMER_W           16
`endif

//--- ssf_timer.v
// Down counter with load; signals when it reaches zero.
// Assumes an active-low reset from the top module that asserts asynchronously.
`timescale 1ns/1ps
`default_nettype none
module ssf_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output reg          zero
);
  reg [W-1:0] cnt_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {W{1'b0}};
      zero    <= 1'b1;
    end else if (load) begin
      cnt_reg <= load_val;
      zero    <= (load_val == {W{1'b0}});
    end else if (cnt_reg != {W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      zero    <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule // ssf_timer
`default_nettype wire

//--- ssf_status_flags.v
// Status flag logic: reset/init bits of the main status register and supply error register.
// Assumes a register read port driven by the SPI/I2C front end, synchronous to clk.
`include "ssf_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ssf_status_flags #(
  parameter DATA_VALID_CYCLES = `SSF_DATA_VALID_CYCLES,
  parameter RECOVERY_CYCLES   = `SSF_RECOVERY_CYCLES
) (
  // Clock and reset.
  input  wire       clk,
  input  wire       rstn,
  input  wire       soft_reset,
  // Register read port from the serial interfaces.
  input  wire       rd_en,
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  // Status field of a data transmission carried the reset flag.
  input  wire       status_tx_reset,
  // Monitor inputs, levels.
  input  wire       undervoltage,
  input  wire       analog_reg_fault,
  input  wire       digital_reg_fault,
  input  wire       otp_reg_fault,
  input  wire       continuity_break,
  // Setting from the lock and write control register.
  input  wire       supply_error_report_disable,
  // Flag outputs.
  output reg        reset_occurred_flag,
  output reg        init_in_progress_flag,
  output reg        supply_error_summary,
  output reg  [7:0] supply_error_status
);
  // Reset synchroniser stages; the second stage is the internal reset.
  reg                    rs1_reg;
  reg                    rs2_reg;
  wire                   rst_n;

  // Initialisation counter and its next value.
  reg [31:0]             init_cnt_reg;
  reg [31:0]             init_cnt_next;
  reg                    init_next;
  wire                   init_done;

  // Next values of the flag registers and the read data register.
  reg                    reset_flag_next;
  reg [7:0]              sup_next;
  reg                    sum_next;
  reg [7:0]              rd_data_next;

  // Monitor levels gathered into register bit positions.
  reg [7:0]              faults;
  wire                   any_fault;
  wire                   timer_zero;

  // Read strobe decodes.
  wire                   main_read;
  wire                   supply_read;
  wire                   clear_reset_flag;

  // True when a read strobe addresses the given register offset.
  function is_addr;
    input       en;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_addr = en && (addr == ofs);
    end
  endfunction

  // Builds the main status byte; bits outside this block read as zero.
  function [7:0] pack_main;
    input sum;
    input res;
    input init;
    begin
      pack_main                      = 8'h00;
      pack_main[`SSF_BIT_SUPPLY_SUM] = sum;
      pack_main[`SSF_BIT_RESET]      = res;
      pack_main[`SSF_BIT_INIT]       = init;
    end
  endfunction

  // Places the five monitor levels at their supply error bit positions.
  function [7:0] pack_faults;
    input uv;
    input ana;
    input dig;
    input otp;
    input cont;
    begin
      pack_faults                   = 8'h00;
      pack_faults[`SSF_BIT_UV]      = uv;
      pack_faults[`SSF_BIT_ANA_REG] = ana;
      pack_faults[`SSF_BIT_DIG_REG] = dig;
      pack_faults[`SSF_BIT_OTP_REG] = otp;
      pack_faults[`SSF_BIT_CONT]    = cont;
    end
  endfunction

  // The pin reset asserts at once but releases two edges later, so no
  // register behind the synchroniser leaves reset on an edge that the pin release may race.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rs2_reg <= rs1_reg;
    end
  end
  assign rst_n = rs2_reg;

  always @* begin
    faults = pack_faults(undervoltage,       // RL4
                         analog_reg_fault,   // RL5
                         digital_reg_fault,  // RL6
                         otp_reg_fault,      // RL7
                         continuity_break);  // RL8
  end
  assign any_fault = |faults;

  // Any fault reloads the shared recovery timer.
  ssf_timer #(.W(`SSF_TIMER_W)) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (any_fault), // RL9
    .load_val (RECOVERY_CYCLES[`SSF_TIMER_W-1:0]),
    .zero     (timer_zero)
  );

  // With reporting disabled, flags follow the monitors; otherwise they clear after recovery.
  // A fault in the same cycle as the expiry keeps the bits, since it also reloads the timer.
  always @* begin
    if (supply_error_report_disable) begin // RL10
      sup_next = faults;
    end else if (timer_zero && !any_fault) begin
      sup_next = 8'h00; // RL14
    end else begin
      sup_next = supply_error_status | faults;
    end
    sum_next = |sup_next; // RL12
  end

  assign main_read        = is_addr(rd_en, rd_addr, `SSF_OFS_MAIN_STATUS);
  assign supply_read      = is_addr(rd_en, rd_addr, `SSF_OFS_SUPPLY_STATUS);
  assign clear_reset_flag = main_read || status_tx_reset;

  // The flag only ever sets through reset, so a clear here cannot race a set.
  always @* begin
    reset_flag_next = reset_occurred_flag;
    if (clear_reset_flag) begin
      reset_flag_next = 1'b0; // RL2
    end
  end

  // Counts from internal reset release until sensor data is valid.
  assign init_done = (init_cnt_reg >= DATA_VALID_CYCLES - 1);

  always @* begin
    init_next     = init_in_progress_flag;
    init_cnt_next = init_cnt_reg;
    if (init_in_progress_flag) begin
      if (init_done) begin
        init_next = 1'b0; // RL3
      end else begin
        init_cnt_next = init_cnt_reg + 32'h00000001;
      end
    end
  end

  // Read data holds between reads; the main byte shows values from before the read.
  always @* begin
    rd_data_next = rd_data;
    if (main_read) begin // RL13
      rd_data_next = pack_main(supply_error_summary, reset_occurred_flag,
                               init_in_progress_flag);
    end else if (supply_read) begin
      rd_data_next = supply_error_status;
    end else if (rd_en) begin
      rd_data_next = 8'h00;
    end
  end

  // Reset and initialisation flags; a soft reset acts like the pin reset.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_occurred_flag   <= 1'b1; // RL1
      init_in_progress_flag <= 1'b1; // RL3
      init_cnt_reg          <= 32'h00000000;
    end else if (soft_reset) begin
      reset_occurred_flag   <= 1'b1; // RL1
      init_in_progress_flag <= 1'b1; // RL3
      init_cnt_reg          <= 32'h00000000;
    end else begin
      reset_occurred_flag   <= reset_flag_next;
      init_in_progress_flag <= init_next;
      init_cnt_reg          <= init_cnt_next;
    end
  end

  // Supply error register and its summary bit, updated together.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_error_status  <= `SSF_RESET_SUPPLY; // RL8
      supply_error_summary <= 1'b0;
    end else if (soft_reset) begin
      supply_error_status  <= `SSF_RESET_SUPPLY;
      supply_error_summary <= 1'b0;
    end else begin
      supply_error_status  <= sup_next;
      supply_error_summary <= sum_next;
    end
  end

  // Read data register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (soft_reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_data_next;
    end
  end
endmodule // ssf_status_flags
`default_nettype wire

//--- ssf_monitor.sv
// Checker on the flag block ports.
// Assumes the bench's recovery count.
`timescale 1ns/1ps
`default_nettype none
module ssf_monitor #(parameter int RECOVERY_CYCLES = 10) (
  input wire logic clk, rstn, soft_reset, rd_en, supply_error_report_disable,
  input wire logic [7:0] rd_addr, rd_data, supply_error_status,
  input wire logic undervoltage, analog_reg_fault, digital_reg_fault, otp_reg_fault,
  input wire logic continuity_break, reset_occurred_flag, init_in_progress_flag,
  input wire logic supply_error_summary);
  wire logic dis = supply_error_report_disable;
  wire logic rd = rd_en && !init_in_progress_flag;
  wire logic [7:0] st = supply_error_status;
  wire logic [7:0] f = {undervoltage, 3'h0, analog_reg_fault, digital_reg_fault,
    otp_reg_fault, continuity_break};
  sequence s_quiet; f == 0 && !dis; endsequence
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || soft_reset);
  AST_SUM: assert property (supply_error_summary == |st) else $error("sum");
  AST_SET: assert property (!init_in_progress_flag |=> (st & $past(f)) == $past(f))
    else $error("set");
  AST_LIVE: assert property (dis && !init_in_progress_flag |=> st == $past(f))
    else $error("live");
  AST_KEEP: assert property (f != 0 && !dis ##1 !dis [*8] |-> st != 0)
    else $error("keep");
  AST_CLR: assert property (s_quiet [*8] ##1 s_quiet [*6] |-> st == 0)
    else $error("clear");
  AST_RDCLR: assert property (rd && rd_addr == 8'h01 |=> !reset_occurred_flag)
    else $error("rdclr");
  AST_RD2: assert property (rd && rd_addr == 8'h02 |=> rd_data == $past(st))
    else $error("rd");
  AST_HOLD: assert property (!rd_en |=> $stable(rd_data)) else $error("hold");
endmodule // ssf_monitor
`default_nettype wire

//--- ssf_host.sv
// Host model reading one status byte per call.
// Assumes the answer lands on the taking edge.
`timescale 1ns/1ps
`default_nettype none
module ssf_host (
  input wire logic       clk,
  input wire logic [7:0] rd_data,
  output logic           rd_en = 1'b0,
  output logic     [7:0] rd_addr = 8'h00);
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2 rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #2 rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
  endtask
endmodule // ssf_host
`default_nettype wire

//--- ssf_status_flags_tb_top.sv
// Flag block bench.
// Assumes host model and checker alongside.
`timescale 1ns/1ps
`default_nettype none
module ssf_status_flags_tb_top;
  logic clk = 0, rstn = 0, soft_reset = 0, status_tx_reset = 0, rd_en, reset_occurred_flag;
  logic supply_error_report_disable = 1, init_in_progress_flag, supply_error_summary;
  logic [4:0] f = 0;
  logic [7:0] rd_addr, rd_data, supply_error_status, d;
  integer n_fail = 0, tests_run = 0, seed = 80, cyc = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 2000) begin n_fail++; stop_test(); end
  ssf_status_flags #(20, 10) ssf_status_flags_i (.*, .undervoltage(f[4]),
    .analog_reg_fault(f[3]), .digital_reg_fault(f[2]), .otp_reg_fault(f[1]),
    .continuity_break(f[0]));
  ssf_host ssf_host_i (.*);
  task automatic chk(input string n, input logic [7:0] s, x);
    tests_run++;
    if (s !== x) begin n_fail++; $display("BAD %s exp %h got %h", n, x, s); end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick; @(posedge clk); #2; endtask
  initial begin
    repeat (4) tick;
    rstn = 1;
    repeat (24) tick;
    ssf_host_i.rd(8'h01, d); chk("main", d, 8'h02);
    ssf_host_i.rd(8'h01, d); chk("reread", d, 8'h00);
    repeat (8) begin
      f = $random(seed);
      ssf_host_i.rd(8'h02, d); chk("live", d, {f[4], 3'h0, f[3:0]});
    end
    f = 0; tick;
    supply_error_report_disable = 0; f = 5'h11; tick; f = 0;
    ssf_host_i.rd(8'h02, d); chk("held", d, 8'h81);
    ssf_host_i.rd(8'h01, d); chk("summary", d, 8'h08);
    repeat (14) tick;
    ssf_host_i.rd(8'h02, d); chk("cleared", d, 8'h00);
    ssf_host_i.rd(8'h05, d); chk("unmapped", d, 8'h00);
    soft_reset = 1; tick; soft_reset = 0;
    chk("soft", {reset_occurred_flag, init_in_progress_flag}, 8'h03);
    status_tx_reset = 1; tick; status_tx_reset = 0;
    chk("tx", reset_occurred_flag, 8'h00);
    stop_test();
  end
endmodule // ssf_status_flags_tb_top
bind ssf_status_flags ssf_monitor #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) ssf_monitor_i (.*);
`default_nettype wire
